// File: mrc_top.sv
// Purpose: Upper MAC control bits, pause halt timing and received frame length check.
// Assumes: 20 MHz clk; collision and carrier arrive from the PHY clock domain.
// Notes:   Pause timer ticks once per quantum_cycles clocks.
// How it works
// - Bit 16 shows live collision, unlatched.
// - Bit 17 shows live carrier sense, unlatched.
// - Self-clearing bit 21 starts statistics counting.
// - Self-clearing bit 22 stops statistics counting.
// - Bit 23 reads statistics running state.
// - Self-clearing bit 24 enables transmitter.
// - Self-clearing bit 25 disables transmitter.
// - Bit 26 reads transmitter enabled state.
// - Self-clearing bit 27 enables receiver.
// - Self-clearing bit 28 disables receiver.
// - Bit 29 reads receiver enabled state.
// - PAUSE frame halts transmit; bit 30 shows.
// - Paused bit clears when transmission resumes.
// - Reserved bits are written zero, read zero.
// - Limit is 14-bit byte count, DA through data.
// - Untagged length at or above limit flags oversize.
// - Tagged frames get limit plus four.
// - Pause acted on only when bit 8 set.
`timescale 1ns/100ps
module mrc_top
    import mrc_pkg::*;
#(
    parameter int QUANTUM_CYCLES = 1
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic           collision_live,
    input  wire logic           carrier_live,
    input  wire mrc_pause_req_s pause_req,
    input  wire mrc_frame_end_s frame_end,
    output logic                stats_running,
    output logic                transmit_running,
    output logic                receive_running,
    output logic                transmit_paused,
    output logic                frame_too_long_flag,
    output logic                frame_status_valid
);
    // A pause timer needs at least one clock per quantum.
    if (QUANTUM_CYCLES < 1) begin : g_bad_quantum
        $error("QUANTUM_CYCLES must be at least one");
    end

    function automatic logic run_next(input logic cur, input logic on_s, input logic off_s);
        logic r;
        r = cur;
        if (off_s) begin
            r = 1'b0;
        end else if (on_s) begin
            r = 1'b1;
        end
        return r;
    endfunction

    logic              acc;
    logic              wr_ctrl;
    logic              wr_limit;
    logic              wr_flow;
    logic [2:0]        col_sync_q;
    logic [2:0]        crs_sync_q;
    logic              col_q;
    logic              crs_q;
    logic [13:0]       limit_q;
    logic              honor_q;
    mrc_pause_e        pstate_q;
    logic [15:0]       quanta_q;
    logic [31:0]       qcnt_q;
    logic              tick;
    logic [14:0]       eff_limit;
    logic              st_n;
    logic              tx_n;
    logic              rx_n;

    assign acc      = psel && penable;
    assign wr_ctrl  = acc && pwrite && (paddr == MRC_OFF_CTRL);
    assign wr_limit = acc && pwrite && (paddr == MRC_OFF_LIMIT);
    assign wr_flow  = acc && pwrite && (paddr == MRC_OFF_FLOW);

    // Strobes are never stored, so they clear themselves.
    assign st_n = run_next(stats_running, wr_ctrl & pwdata[MRC_BIT_STATS_ON],
                           wr_ctrl & pwdata[MRC_BIT_STATS_OFF]);
    assign tx_n = run_next(transmit_running, wr_ctrl & pwdata[MRC_BIT_TX_ON],
                           wr_ctrl & pwdata[MRC_BIT_TX_OFF]);
    assign rx_n = run_next(receive_running, wr_ctrl & pwdata[MRC_BIT_RX_ON],
                           wr_ctrl & pwdata[MRC_BIT_RX_OFF]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stats_running    <= 1'b0;
            transmit_running <= 1'b0;
            receive_running  <= 1'b0;
        end else begin
            stats_running    <= st_n;
            transmit_running <= tx_n;
            receive_running  <= rx_n;
        end
    end

    // Second and third stages must agree before the live view changes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            col_sync_q <= 3'h0;
            crs_sync_q <= 3'h0;
            col_q      <= 1'b0;
            crs_q      <= 1'b0;
        end else begin
            col_sync_q <= {col_sync_q[1:0], collision_live};
            crs_sync_q <= {crs_sync_q[1:0], carrier_live};
            if (col_sync_q[1] == col_sync_q[2]) begin
                col_q <= col_sync_q[2];
            end
            if (crs_sync_q[1] == crs_sync_q[2]) begin
                crs_q <= crs_sync_q[2];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            limit_q <= MRC_LIMIT_RST;
            honor_q <= 1'b0;
        end else begin
            if (wr_limit) begin
                limit_q <= pwdata[MRC_LIMIT_W-1:0];
            end
            if (wr_flow) begin
                honor_q <= pwdata[MRC_BIT_HONOR_PAUSE];
            end
        end
    end

    assign tick = (qcnt_q == 32'(QUANTUM_CYCLES - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pstate_q        <= MRC_RUN;
            quanta_q        <= 16'h0000;
            qcnt_q          <= 32'h0000_0000;
            transmit_paused <= 1'b0;
        end else begin
            if (pause_req.valid && honor_q && transmit_running) begin
                quanta_q        <= pause_req.quanta;
                qcnt_q          <= 32'h0000_0000;
                pstate_q        <= (pause_req.quanta != 16'h0000) ? MRC_HALTED : MRC_RUN;
                transmit_paused <= (pause_req.quanta != 16'h0000);
            end else begin
                case (pstate_q)
                    MRC_RUN: begin
                        transmit_paused <= 1'b0;
                    end
                    MRC_HALTED: begin
                        qcnt_q <= tick ? 32'h0000_0000 : qcnt_q + 32'h0000_0001;
                        if (tick) begin
                            quanta_q <= quanta_q - 16'h0001;
                            if (quanta_q == 16'h0001) begin
                                pstate_q        <= MRC_RUN;
                                transmit_paused <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        pstate_q        <= MRC_RUN;
                        transmit_paused <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign eff_limit = {1'b0, limit_q} + (frame_end.vlan ? {1'b0, MRC_VLAN_EXTRA} : 15'h0000);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_too_long_flag <= 1'b0;
            frame_status_valid  <= 1'b0;
        end else begin
            frame_status_valid <= frame_end.valid && receive_running;
            if (frame_end.valid && receive_running) begin
                frame_too_long_flag <= ({1'b0, frame_end.length} >= eff_limit);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == MRC_OFF_CTRL || paddr == MRC_OFF_LIMIT
                                              || paddr == MRC_OFF_FLOW);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    MRC_OFF_CTRL: begin
                        prdata[MRC_BIT_COLLISION] <= col_q;
                        prdata[MRC_BIT_CARRIER]   <= crs_q;
                        prdata[MRC_BIT_STATS_RUN] <= stats_running;
                        prdata[MRC_BIT_TX_RUN]    <= transmit_running;
                        prdata[MRC_BIT_RX_RUN]    <= receive_running;
                        prdata[MRC_BIT_PAUSED]    <= transmit_paused;
                    end
                    MRC_OFF_LIMIT: begin
                        prdata[MRC_LIMIT_W-1:0] <= limit_q;
                    end
                    MRC_OFF_FLOW: begin
                        prdata[MRC_BIT_HONOR_PAUSE] <= honor_q;
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    sequence s_both_strobes;
        wr_ctrl && pwdata[MRC_BIT_TX_ON] && pwdata[MRC_BIT_TX_OFF];
    endsequence

    chk_tx_off_wins: assert property (@(posedge clk) disable iff (rst)
        s_both_strobes |=> !transmit_running)
        else $error("transmit enabled after both strobes");
    chk_stats_on: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && pwdata[MRC_BIT_STATS_ON] && !pwdata[MRC_BIT_STATS_OFF]) |=> stats_running)
        else $error("statistics not started");
    chk_stats_off: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && pwdata[MRC_BIT_STATS_OFF]) |=> !stats_running)
        else $error("statistics not stopped");
    chk_tx_on: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && pwdata[MRC_BIT_TX_ON] && !pwdata[MRC_BIT_TX_OFF]) |=> transmit_running)
        else $error("transmitter not enabled");
    chk_rx_hold: assert property (@(posedge clk) disable iff (rst)
        !wr_ctrl |=> $stable(receive_running))
        else $error("receiver state moved without a write");
    chk_rx_off: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && pwdata[MRC_BIT_RX_OFF]) |=> !receive_running)
        else $error("receiver not disabled");
    chk_pause_ignored: assert property (@(posedge clk) disable iff (rst)
        (!transmit_paused && pause_req.valid && !honor_q) |=> !transmit_paused)
        else $error("pause taken while not honoured");
    chk_pause_enter: assert property (@(posedge clk) disable iff (rst)
        (pause_req.valid && honor_q && transmit_running && pause_req.quanta != 16'h0000)
        |=> transmit_paused)
        else $error("pause not entered");
    chk_oversize: assert property (@(posedge clk) disable iff (rst)
        (frame_end.valid && receive_running && !frame_end.vlan && frame_end.length >= limit_q)
        |=> frame_too_long_flag && frame_status_valid)
        else $error("oversize frame not flagged");
    chk_vlan_extra: assert property (@(posedge clk) disable iff (rst)
        (frame_end.valid && receive_running && frame_end.vlan
         && {1'b0, frame_end.length} < {1'b0, limit_q} + 15'h0004)
        |=> !frame_too_long_flag)
        else $error("tagged frame flagged below extended limit");
    chk_ctrl_read: assert property (@(posedge clk) disable iff (rst)
        (psel && !penable && !pwrite && paddr == MRC_OFF_CTRL)
        |=> pready && prdata[MRC_BIT_TX_RUN] == $past(transmit_running) && prdata[31] == 1'b0)
        else $error("control read mismatch");

    // Named steps that the read, pause and frame checks below build on.
    sequence s_ctrl_read_setup;
        psel && !penable && !pwrite && (paddr == MRC_OFF_CTRL);
    endsequence

    sequence s_any_read_setup;
        psel && !penable && !pwrite;
    endsequence

    sequence s_pause_taken;
        pause_req.valid && honor_q && transmit_running;
    endsequence

    sequence s_last_quantum;
        (pstate_q == MRC_HALTED) && tick && (quanta_q == 16'h0001) && !pause_req.valid;
    endsequence

    sequence s_frame_seen;
        frame_end.valid && receive_running;
    endsequence

    // A read returns the state held at its setup edge.
    chk_col_read: assert property (@(posedge clk) disable iff (rst)
        s_ctrl_read_setup
        |=> prdata[MRC_BIT_COLLISION] == $past(col_q))
        else $error("collision view wrong on read");
    chk_crs_read: assert property (@(posedge clk) disable iff (rst)
        s_ctrl_read_setup
        |=> prdata[MRC_BIT_CARRIER] == $past(crs_q))
        else $error("carrier view wrong on read");
    chk_stats_read: assert property (@(posedge clk) disable iff (rst)
        s_ctrl_read_setup
        |=> prdata[MRC_BIT_STATS_RUN] == $past(stats_running))
        else $error("statistics state wrong on read");
    chk_rx_read: assert property (@(posedge clk) disable iff (rst)
        s_ctrl_read_setup
        |=> prdata[MRC_BIT_RX_RUN] == $past(receive_running))
        else $error("receiver state wrong on read");
    chk_paused_read: assert property (@(posedge clk) disable iff (rst)
        s_ctrl_read_setup
        |=> prdata[MRC_BIT_PAUSED] == $past(transmit_paused))
        else $error("paused state wrong on read");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        s_any_read_setup
        |=> (prdata[31] == 1'b0) && (prdata[20:18] == 3'h0) && (prdata[15:14] == 2'h0))
        else $error("reserved bits not zero");

    // Strobes act once and leave no stored trace.
    chk_tx_off: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && pwdata[MRC_BIT_TX_OFF])
        |=> !transmit_running)
        else $error("transmitter not disabled");
    chk_rx_on: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && pwdata[MRC_BIT_RX_ON] && !pwdata[MRC_BIT_RX_OFF])
        |=> receive_running)
        else $error("receiver not enabled");
    chk_stats_hold: assert property (@(posedge clk) disable iff (rst)
        !wr_ctrl |=> $stable(stats_running))
        else $error("statistics state moved without a write");
    chk_tx_hold: assert property (@(posedge clk) disable iff (rst)
        !wr_ctrl |=> $stable(transmit_running))
        else $error("transmitter state moved without a write");

    // A taken pause reloads the timer; the last quantum releases transmit.
    chk_pause_restart: assert property (@(posedge clk) disable iff (rst)
        s_pause_taken |=> (quanta_q == $past(pause_req.quanta)))
        else $error("pause time not loaded");
    chk_pause_release: assert property (@(posedge clk) disable iff (rst)
        s_last_quantum |=> !transmit_paused && (pstate_q == MRC_RUN))
        else $error("pause not released");
    chk_pause_holds: assert property (@(posedge clk) disable iff (rst)
        (transmit_paused && !pause_req.valid && !(tick && (quanta_q == 16'h0001)))
        |=> transmit_paused)
        else $error("pause ended early");
    chk_state_match: assert property (@(posedge clk) disable iff (rst)
        transmit_paused == (pstate_q == MRC_HALTED))
        else $error("paused flag and pause state differ");

    // Length checks run only while the receiver is on.
    chk_undersize: assert property (@(posedge clk) disable iff (rst)
        (frame_end.valid && receive_running && !frame_end.vlan && (frame_end.length < limit_q))
        |=> !frame_too_long_flag && frame_status_valid)
        else $error("short frame flagged");
    chk_vlan_over: assert property (@(posedge clk) disable iff (rst)
        (frame_end.valid && receive_running && frame_end.vlan
         && ({1'b0, frame_end.length} >= ({1'b0, limit_q} + {1'b0, MRC_VLAN_EXTRA})))
        |=> frame_too_long_flag)
        else $error("tagged frame at extended limit not flagged");
    chk_status_pulse: assert property (@(posedge clk) disable iff (rst)
        s_frame_seen |=> frame_status_valid)
        else $error("frame status not posted");
    chk_frame_ignored: assert property (@(posedge clk) disable iff (rst)
        !(frame_end.valid && receive_running) |=> !frame_status_valid)
        else $error("frame status posted without a frame");
    chk_flag_holds: assert property (@(posedge clk) disable iff (rst)
        !(frame_end.valid && receive_running) |=> $stable(frame_too_long_flag))
        else $error("oversize flag moved without a frame");

    chk_limit_write: assert property (@(posedge clk) disable iff (rst)
        wr_limit |=> (limit_q == $past(pwdata[MRC_LIMIT_W-1:0])))
        else $error("limit not stored");
endmodule

// File: mrc_pkg.sv
// Purpose: Shared constants and carrier types for the MAC run control and frame limit block.
// Assumes: APB slave with 32-bit data; one aligned word per register.
// Notes:   Offsets are byte addresses.
package mrc_pkg;
    localparam logic [7:0]  MRC_OFF_CTRL        = 8'h00;
    localparam logic [7:0]  MRC_OFF_LIMIT       = 8'h04;
    localparam logic [7:0]  MRC_OFF_FLOW        = 8'h08;
    localparam int          MRC_BIT_COLLISION   = 16;
    localparam int          MRC_BIT_CARRIER     = 17;
    localparam int          MRC_BIT_STATS_ON    = 21;
    localparam int          MRC_BIT_STATS_OFF   = 22;
    localparam int          MRC_BIT_STATS_RUN   = 23;
    localparam int          MRC_BIT_TX_ON       = 24;
    localparam int          MRC_BIT_TX_OFF      = 25;
    localparam int          MRC_BIT_TX_RUN      = 26;
    localparam int          MRC_BIT_RX_ON       = 27;
    localparam int          MRC_BIT_RX_OFF      = 28;
    localparam int          MRC_BIT_RX_RUN      = 29;
    localparam int          MRC_BIT_PAUSED      = 30;
    localparam int          MRC_BIT_HONOR_PAUSE = 8;
    localparam int          MRC_LIMIT_W         = 14;
    localparam logic [13:0] MRC_LIMIT_RST       = 14'h05EE;
    localparam logic [13:0] MRC_VLAN_EXTRA      = 14'h0004;
    localparam int          MRC_QUANTUM_BITS    = 512;
    localparam int          MRC_PAUSE_W         = 16;

    typedef struct packed {
        logic        valid;
        logic        vlan;
        logic [13:0] length;
    } mrc_frame_end_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] quanta;
    } mrc_pause_req_s;

    typedef enum logic [0:0] {
        MRC_RUN    = 1'b0,
        MRC_HALTED = 1'b1
    } mrc_pause_e;
endpackage

// File: mrc_phy_model.sv
// Purpose: Far-side model that feeds line levels, pause requests and frame ends.
// Assumes: All changes are made just after a rising clk edge.
// Notes:   Released request fields carry the inverse of the last value.
`timescale 1ns/100ps
module mrc_phy_model
    import mrc_pkg::*;
(
    input  wire logic clk,
    output logic      collision_live,
    output logic      carrier_live,
    output mrc_pause_req_s pause_req,
    output mrc_frame_end_s frame_end
);
    initial begin
        collision_live = 1'b0;
        carrier_live   = 1'b0;
        pause_req      = '0;
        frame_end      = '0;
    end

    task automatic set_lines(input logic col, input logic crs);
        @(posedge clk);
        collision_live <= col;
        carrier_live   <= crs;
    endtask

    // A gap of idle cycles lets the model answer promptly or slowly.
    task automatic send_pause(input logic [15:0] q, input int gap);
        repeat (gap + 1) @(posedge clk);
        pause_req <= '{valid: 1'b1, quanta: q};
        @(posedge clk);
        pause_req <= '{valid: 1'b0, quanta: ~q};
    endtask

    task automatic send_frame(input logic [13:0] len, input logic vl, input int gap);
        repeat (gap + 1) @(posedge clk);
        frame_end <= '{valid: 1'b1, vlan: vl, length: len};
        @(posedge clk);
        frame_end <= '{valid: 1'b0, vlan: ~vl, length: ~len};
    endtask
endmodule

// File: tb_mrc_top.sv
// Purpose: Self-checking bench for run control, pause halt and frame limit.
// Assumes: Zero wait state APB slave; pause quantum shortened to two clocks.
// Notes:   Expected values are built from the package bit positions.
`timescale 1ns/100ps
module tb_mrc_top
    import mrc_pkg::*;
();
    localparam int          QC      = 2;
    localparam logic [31:0] RUN_ALL = (32'h1 << MRC_BIT_STATS_RUN) | (32'h1 << MRC_BIT_TX_RUN)
                                    | (32'h1 << MRC_BIT_RX_RUN);
    logic           clk     = 1'b0;
    logic           rst     = 1'b1;
    logic           psel    = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite  = 1'b0;
    logic [7:0]     paddr   = '0;
    logic [31:0]    pwdata  = '0;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           collision_live;
    logic           carrier_live;
    mrc_pause_req_s pause_req;
    mrc_frame_end_s frame_end;
    logic           stats_running;
    logic           transmit_running;
    logic           receive_running;
    logic           transmit_paused;
    logic           frame_too_long_flag;
    logic           frame_status_valid;
    logic [31:0]    rdata;
    logic           err;
    int             failures        = 0;
    int             samples_checked = 0;
    int             cycles          = 0;
    int             n;

    mrc_top #(.QUANTUM_CYCLES(QC)) i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .collision_live, .carrier_live, .pause_req, .frame_end,
        .stats_running, .transmit_running, .receive_running, .transmit_paused,
        .frame_too_long_flag, .frame_status_valid);
    mrc_phy_model i_phy (.clk, .collision_live, .carrier_live, .pause_req, .frame_end);

    always #25 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures = failures + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (pready !== 1'b1) failures++;
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(rdata, exp);
        chk({31'h0, err}, 32'h0);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(MRC_OFF_CTRL, 32'h0);
        rd(MRC_OFF_LIMIT, {18'h0, MRC_LIMIT_RST});
        rd(MRC_OFF_FLOW, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk({rdata[30:0], err}, 32'h1);
        $display("test reset_and_map done");
        for (int f = 0; f < 3; f++) begin
            wr(MRC_OFF_CTRL, 32'h1 << (MRC_BIT_STATS_ON + 3 * f));
            wr(MRC_OFF_CTRL, 32'h0);
            rd(MRC_OFF_CTRL, 32'h1 << (MRC_BIT_STATS_RUN + 3 * f));
            wr(MRC_OFF_CTRL, 32'h1 << (MRC_BIT_STATS_OFF + 3 * f));
            rd(MRC_OFF_CTRL, 32'h0);
            wr(MRC_OFF_CTRL, 32'h3 << (MRC_BIT_STATS_ON + 3 * f));
            rd(MRC_OFF_CTRL, 32'h0);
        end
        wr(MRC_OFF_CTRL, RUN_ALL >> 2);
        rd(MRC_OFF_CTRL, RUN_ALL);
        chk({29'h0, stats_running, transmit_running, receive_running}, 32'h7);
        $display("test run_control done");
        i_phy.set_lines(1'b1, 1'b0);
        repeat (8) @(posedge clk);
        rd(MRC_OFF_CTRL, RUN_ALL | (32'h1 << MRC_BIT_COLLISION));
        i_phy.set_lines(1'b0, 1'b1);
        repeat (8) @(posedge clk);
        rd(MRC_OFF_CTRL, RUN_ALL | (32'h1 << MRC_BIT_CARRIER));
        i_phy.set_lines(1'b0, 1'b0);
        repeat (8) @(posedge clk);
        rd(MRC_OFF_CTRL, RUN_ALL);
        $display("test live_lines done");
        wr(MRC_OFF_LIMIT, 32'd100);
        rd(MRC_OFF_LIMIT, 32'd100);
        for (int k = 0; k < 4; k++) begin
            i_phy.send_frame((k < 2) ? 14'(99 + k) : 14'(101 + k), k >= 2, k);
            @(posedge clk);
            chk({30'h0, frame_status_valid, frame_too_long_flag}, {30'h0, 1'b1, k[0]});
        end
        $display("test frame_limit done");
        i_phy.send_pause(16'd5, 0);
        repeat (3) @(posedge clk);
        chk({31'h0, transmit_paused}, 32'h0);
        wr(MRC_OFF_FLOW, 32'h1 << MRC_BIT_HONOR_PAUSE);
        i_phy.send_pause(16'd5, 2);
        @(posedge clk);
        n = 0;
        while (transmit_paused === 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
        end
        chk(32'(n), 32'(5 * QC));
        i_phy.send_pause(16'd40, 0);
        rd(MRC_OFF_CTRL, RUN_ALL | (32'h1 << MRC_BIT_PAUSED));
        i_phy.send_pause(16'd0, 0);
        @(posedge clk);
        chk({30'h0, transmit_paused, transmit_running}, 32'h1);
        $display("test pause done");
        wr(MRC_OFF_CTRL, 32'h1 << MRC_BIT_RX_OFF);
        i_phy.send_frame(14'h000A, 1'b0, 0);
        @(posedge clk);
        chk({30'h0, frame_status_valid, frame_too_long_flag}, 32'h1);
        $display("test receiver_off done");
        wrap_up();
    end
endmodule
